// >>> rtl/decoder_bus_map.vh
`ifndef DECODER_BUS_MAP_VH
`define DECODER_BUS_MAP_VH

// ==========================================================================
// Access kinds on the user request port.
`define KIND_RAM_RAW 3'h0
`define KIND_ROM_RAW 3'h1
`define KIND_FRAME_BUF 3'h2
`define KIND_PULSE_BUF 3'h3
`define KIND_RECOVERY 3'h4
`define KIND_AUTH_CNT 3'h5
`define KIND_STATUS_BUF 3'h6
`define KIND_ROM_CONFIG 3'h7

// ==========================================================================
// RAM map.
`define RAM_FRAME_BUF0 11'h000
`define RAM_FRAME_BUF1 11'h100
`define RAM_PROG_KNAPSACK 11'h200
`define RAM_PROG_HASH 11'h368
`define RAM_RECOVERY_LOW 11'h400
`define RAM_AUX_COUNTER 11'h402
`define RAM_PRINCIPAL_COUNTER 11'h406
`define RAM_STATUS_BUF0 11'h410
`define RAM_STATUS_BUF1 11'h430
`define RAM_FRAME_ANALYSIS_OFS 11'h00a
`define RAM_PULSE_BUF 11'h600

// ==========================================================================
// ROM map.
`define ROM_HEADER1 11'h000
`define ROM_HEADER2 11'h001
`define ROM_HEADER3 11'h002
`define ROM_POS_WINDOW 11'h003
`define ROM_NEG_WINDOW 11'h004
`define ROM_CHANNEL_PTR 11'h005
`define ROM_PACKET_HDR 11'h006
`define ROM_FREQ_TABLE 11'h100
`define ROM_FIXED_KNAPSACK 11'h200
`define ROM_FIXED_HASH 11'h368

// ==========================================================================
// Field masks applied to ROM reads.
`define HEADER1_FLAG_MASK 8'hcf
`define CHANNEL_PTR_MASK 8'h3f

// ==========================================================================
// Timing counts in master clock periods.
`define FAULT_MIN_TCK 32
`define FAULT_MAX_TCK 64
`define FAULT_LIMIT 7'h28
`define ACK_SETTLE 7'h04
`define UNIT_CLOCKS_DIV_OFF 40960
`define UNIT_CLOCKS_DIV_ON 8192

// ==========================================================================
// Pin reset values.
`define RST_LOCAL_ADDR 11'h000
`define RST_LOCAL_DATA 8'h00

`endif

// >>> rtl/local_bus_pulse.v
// Contract
// - Strobe pulse_channel_strobe_n low while channel id drives local_data, no address tied.
// - local_ack ends the strobe cycle, so slow latches may stretch it.
// - pulse_enable_out stays high exactly the commanded pulse length.
// - pulse_divide_sel high shortens every pulse length by five.
// - Code maps to unit times two to the code, plus one clock.
// - First pulse rises between half and one and a half units after legal.
// - About one unit gap between one pulse falling and the next rising.
// - Cycle starts with direction, select and address; memory ends it with local_ack.
// - Fault timer runs while a select is active; abort within 32 to 64 clocks.
// - 11-bit address and 8-bit data reach 2K RAM and 1K ROM.
// - Recovery counter uses RAM select if tail select high, else the counter store.
// - RAM holds two frame buffers, keys and the pulse buffer at fixed bases.
// - Frame buffer keeps length at offset 0, words fill downward to offset 1.
// - Pulse buffer keeps length at 600, first word at 600 plus X.
// - Recovery low byte at 400, counters least significant first at 402 and 406.
// - Two status buffers at 410 and 430, frame analysis octets after auth octets.
// - Bypass and control flag bits in header octet 1 are ignored.
// - ROM holds frequency table at 100, knapsack at 200, hashing key at 368.
// - Knapsack coefficients stored least significant octet first.
// - Hashing key stored bit reversed starting at 368.
`timescale 1ns/10ps
`include "decoder_bus_map.vh"

module local_bus_pulse #(
   parameter UNIT_DIV_OFF = `UNIT_CLOCKS_DIV_OFF,
   parameter UNIT_DIV_ON = `UNIT_CLOCKS_DIV_ON
) (
   // Clock, reset and freeze.
   input wire core_clk,
   input wire rstn,
   input wire clk_en,
   // Memory access request port.
   input wire acc_req,
   input wire acc_write,
   input wire [2:0] acc_kind,
   input wire acc_bank,
   input wire [9:0] acc_index,
   input wire [7:0] acc_wdata,
   output wire acc_ready,
   output reg acc_done,
   output reg acc_fault,
   output reg [7:0] acc_rdata,
   // Pulse command port.
   input wire pulse_cmd_valid,
   input wire pulse_first,
   input wire [7:0] pulse_channel,
   input wire [2:0] pulse_code,
   output wire pulse_cmd_ready,
   output reg pulse_fault,
   // Configuration pins.
   input wire tail_length_select,
   input wire pulse_divide_sel,
   // Local bus pins.
   output reg [10:0] local_addr,
   input wire [7:0] local_data_in,
   output reg [7:0] local_data_out,
   output reg local_data_oe_n,
   output reg read_write_n,
   output reg ram_select_n,
   output reg rom_select_n,
   output reg counter_store_select,
   input wire local_ack,
   // Pulse unit pins.
   output reg pulse_channel_strobe_n,
   output reg pulse_enable_out
);

   // ==========================================================================
   // Reset release.
   reg rst_a_q;
   reg rst_n_s;

   always @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         rst_a_q <= 1'b0;
         rst_n_s <= 1'b0;
      end else begin
         rst_a_q <= 1'b1;
         rst_n_s <= rst_a_q;
      end
   end

   // ==========================================================================
   // Pin synchronisers. A bit is taken once stages two and three agree,
   // which filters a one-cycle glitch at the cost of four cycles latency.
   localparam SW = 11;
   wire [SW-1:0] pin_raw;
   reg [SW-1:0] s1_q;
   reg [SW-1:0] s2_q;
   reg [SW-1:0] s3_q;
   reg [SW-1:0] pin_q;

   assign pin_raw = {local_ack, tail_length_select, pulse_divide_sel, local_data_in};

   always @(posedge core_clk or negedge rst_n_s) begin
      if (!rst_n_s) begin
         s1_q <= {SW{1'b0}};
         s2_q <= {SW{1'b0}};
         s3_q <= {SW{1'b0}};
         pin_q <= {SW{1'b0}};
      end else if (clk_en) begin
         s1_q <= pin_raw;
         s2_q <= s1_q;
         s3_q <= s2_q;
         pin_q <= (s2_q & s3_q) | (pin_q & (s2_q | s3_q));
      end
   end

   wire ack_s = pin_q[10];
   wire tail_s = pin_q[9];
   wire div_s = pin_q[8];
   wire [7:0] data_s = pin_q[7:0];

   // ==========================================================================
   // Address forming for the request port.
   reg [10:0] addr_d;
   reg is_rom_d;
   reg is_recovery_d;

   always @* begin
      addr_d = {1'b0, acc_index};
      is_rom_d = 1'b0;
      is_recovery_d = 1'b0;
      case (acc_kind)
         `KIND_ROM_RAW: begin
            addr_d = {1'b0, acc_index};
            is_rom_d = 1'b1;
         end
         `KIND_ROM_CONFIG: begin
            addr_d = `ROM_HEADER1 + {8'h00, acc_index[2:0]};
            is_rom_d = 1'b1;
         end
         `KIND_FRAME_BUF: begin
            // Offset 0 is the length, offsets X down to 1 carry the frame.
            addr_d = (acc_bank ? `RAM_FRAME_BUF1 : `RAM_FRAME_BUF0) + {3'h0, acc_index[7:0]};
         end
         `KIND_PULSE_BUF: begin
            addr_d = `RAM_PULSE_BUF + {3'h0, acc_index[7:0]};
         end
         `KIND_RECOVERY: begin
            addr_d = `RAM_RECOVERY_LOW;
            is_recovery_d = 1'b1;
         end
         `KIND_AUTH_CNT: begin
            addr_d = (acc_bank ? `RAM_PRINCIPAL_COUNTER : `RAM_AUX_COUNTER) + {9'h000, acc_index[1:0]};
         end
         `KIND_STATUS_BUF: begin
            addr_d = (acc_bank ? `RAM_STATUS_BUF1 : `RAM_STATUS_BUF0) + {7'h00, acc_index[3:0]};
         end
         default: begin
            addr_d = {1'b0, acc_index};
         end
      endcase
   end

   // ==========================================================================
   // Local bus sequencer. The strobe of the pulse unit wins over a pending
   // memory access, so a strobe waits only for a memory cycle already on the bus.
   localparam B_IDLE = 2'h0;
   localparam B_MEM = 2'h1;
   localparam B_STB = 2'h2;
   localparam B_REL = 2'h3;

   reg [1:0] bus_q;
   reg [6:0] fault_q;
   reg rom_cycle_q;
   reg [10:0] cyc_addr_q;
   reg stb_req;
   reg stb_done_q;
   reg stb_fault_q;
   reg [7:0] chan_q;

   wire fault_hit = (fault_q == `FAULT_LIMIT);
   // Data and acknowledge share one synchroniser, so an acknowledge tied high
   // must wait until the data of this cycle has come through.
   wire ack_ok = ack_s && (fault_q >= `ACK_SETTLE);

   assign acc_ready = (bus_q == B_IDLE) && !stb_req;

   always @(posedge core_clk or negedge rst_n_s) begin
      if (!rst_n_s) begin
         bus_q <= B_IDLE;
         fault_q <= 7'h00;
         rom_cycle_q <= 1'b0;
         cyc_addr_q <= `RST_LOCAL_ADDR;
         local_addr <= `RST_LOCAL_ADDR;
         local_data_out <= `RST_LOCAL_DATA;
         local_data_oe_n <= 1'b1;
         read_write_n <= 1'b1;
         ram_select_n <= 1'b1;
         rom_select_n <= 1'b1;
         counter_store_select <= 1'b0;
         pulse_channel_strobe_n <= 1'b1;
         acc_done <= 1'b0;
         acc_fault <= 1'b0;
         acc_rdata <= 8'h00;
         stb_done_q <= 1'b0;
         stb_fault_q <= 1'b0;
      end else if (clk_en) begin
         acc_done <= 1'b0;
         acc_fault <= 1'b0;
         stb_done_q <= 1'b0;
         stb_fault_q <= 1'b0;
         case (bus_q)
            B_IDLE: begin
               fault_q <= 7'h00;
               if (stb_req) begin
                  // The address bus is left alone here.
                  local_data_out <= chan_q;
                  local_data_oe_n <= 1'b0;
                  pulse_channel_strobe_n <= 1'b0;
                  bus_q <= B_STB;
               end else if (acc_req) begin
                  local_addr <= addr_d;
                  cyc_addr_q <= addr_d;
                  rom_cycle_q <= is_rom_d;
                  read_write_n <= ~acc_write;
                  local_data_out <= acc_wdata;
                  local_data_oe_n <= ~acc_write | is_rom_d;
                  if (is_rom_d) begin
                     rom_select_n <= 1'b0;
                  end else if (is_recovery_d && !tail_s) begin
                     counter_store_select <= 1'b1;
                  end else begin
                     ram_select_n <= 1'b0;
                  end
                  bus_q <= B_MEM;
               end
            end
            B_MEM: begin
               fault_q <= fault_q + 7'h01;
               if (ack_ok) begin
                  // A held-high acknowledge completes once the data has settled.
                  if (!rom_cycle_q) begin
                     acc_rdata <= data_s;
                  end else if (cyc_addr_q == `ROM_HEADER1) begin
                     acc_rdata <= data_s & `HEADER1_FLAG_MASK;
                  end else if (cyc_addr_q == `ROM_CHANNEL_PTR) begin
                     acc_rdata <= data_s & `CHANNEL_PTR_MASK;
                  end else begin
                     acc_rdata <= data_s;
                  end
                  acc_done <= 1'b1;
                  bus_q <= B_REL;
               end else if (fault_hit) begin
                  acc_fault <= 1'b1;
                  bus_q <= B_REL;
               end
               if (ack_ok || fault_hit) begin
                  ram_select_n <= 1'b1;
                  rom_select_n <= 1'b1;
                  counter_store_select <= 1'b0;
               end
            end
            B_STB: begin
               fault_q <= fault_q + 7'h01;
               if (ack_ok || fault_hit) begin
                  pulse_channel_strobe_n <= 1'b1;
                  stb_done_q <= ack_ok;
                  stb_fault_q <= ~ack_ok;
                  bus_q <= B_REL;
               end
            end
            default: begin
               // Data is dropped one cycle after the strobe rises so the
               // latch sees it stable across its closing edge.
               local_data_oe_n <= 1'b1;
               read_write_n <= 1'b1;
               bus_q <= B_IDLE;
            end
         endcase
      end
   end

   // ==========================================================================
   // Pulse unit.
   localparam P_IDLE = 2'h0;
   localparam P_WAIT = 2'h1;
   localparam P_STB = 2'h2;
   localparam P_ON = 2'h3;

   reg [1:0] pu_q;
   reg [22:0] cnt_q;
   reg [22:0] len_q;
   reg [22:0] unit_q;

   wire [22:0] unit_now = div_s ? UNIT_DIV_ON[22:0] : UNIT_DIV_OFF[22:0];

   assign pulse_cmd_ready = (pu_q == P_IDLE);

   always @* begin
      stb_req = (pu_q == P_STB) && !stb_done_q && !stb_fault_q;
   end

   always @(posedge core_clk or negedge rst_n_s) begin
      if (!rst_n_s) begin
         pu_q <= P_IDLE;
         cnt_q <= 23'h000000;
         len_q <= 23'h000000;
         unit_q <= 23'h000000;
         chan_q <= 8'h00;
         pulse_enable_out <= 1'b0;
         pulse_fault <= 1'b0;
      end else if (clk_en) begin
         pulse_fault <= 1'b0;
         case (pu_q)
            P_IDLE: begin
               if (pulse_cmd_valid) begin
                  chan_q <= pulse_channel;
                  unit_q <= unit_now;
                  len_q <= (unit_now << pulse_code) + 23'h000001;
                  cnt_q <= 23'h000000;
                  pu_q <= P_WAIT;
               end
            end
            P_WAIT: begin
               // One unit from legal, or from the previous fall; the strobe
               // adds far less than half a unit, keeping both windows met.
               cnt_q <= cnt_q + 23'h000001;
               if (cnt_q == unit_q - 23'h000001) begin
                  pu_q <= P_STB;
               end
            end
            P_STB: begin
               cnt_q <= 23'h000000;
               if (stb_done_q) begin
                  pulse_enable_out <= 1'b1;
                  pu_q <= P_ON;
               end else if (stb_fault_q) begin
                  // No pulse without a latched channel.
                  pulse_fault <= 1'b1;
                  pu_q <= P_IDLE;
               end
            end
            default: begin
               cnt_q <= cnt_q + 23'h000001;
               if (cnt_q == len_q - 23'h000001) begin
                  pulse_enable_out <= 1'b0;
                  pu_q <= P_IDLE;
               end
            end
         endcase
      end
   end

endmodule // local_bus_pulse

// >>> tb/local_bus_pulse_properties.sv
`timescale 1ns/10ps
// ==========
// Pin checker for the local bus and the pulse unit.
module local_bus_pulse_properties #(
   parameter UNIT_DIV_OFF = 40960,
   parameter UNIT_DIV_ON = 8192
) (
   // Clock, reset and user side.
   input wire core_clk,
   input wire rstn,
   input wire pulse_cmd_valid,
   input wire pulse_cmd_ready,
   input wire [2:0] pulse_code,
   input wire pulse_divide_sel,
   input wire acc_done,
   input wire acc_fault,
   input wire pulse_fault,
   // Local bus and pulse pins.
   input wire [10:0] local_addr,
   input wire [7:0] local_data_out,
   input wire local_data_oe_n,
   input wire read_write_n,
   input wire ram_select_n,
   input wire rom_select_n,
   input wire counter_store_select,
   input wire local_ack,
   input wire pulse_channel_strobe_n,
   input wire pulse_enable_out
);
   wire sel_any = !ram_select_n || !rom_select_n || counter_store_select;
   logic [31:0] en_cnt_q;
   logic [31:0] width_q;
   logic [6:0] sel_cnt_q;
   // The width is latched at acceptance, because the unit is sampled there too.
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         en_cnt_q <= 0;
         width_q <= 0;
         sel_cnt_q <= 7'h00;
      end else begin
         en_cnt_q <= pulse_enable_out ? en_cnt_q + 1 : 0;
         sel_cnt_q <= (sel_any && !local_ack) ? sel_cnt_q + 7'h01 : 7'h00;
         if (pulse_cmd_valid && pulse_cmd_ready)
            width_q <= ((pulse_divide_sel ? UNIT_DIV_ON : UNIT_DIV_OFF) << pulse_code) + 1;
      end
   end
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rstn);
   property p_strobe_hold;
      !pulse_channel_strobe_n && !$past(pulse_channel_strobe_n) |-> $stable(local_data_out) && !local_data_oe_n;
   endproperty
   a_strobe_hold: assert property (p_strobe_hold) else $error("channel id moved");
   property p_strobe_alone;
      !pulse_channel_strobe_n |-> !sel_any && $stable(local_addr);
   endproperty
   a_strobe_alone: assert property (p_strobe_alone) else $error("strobe not alone");
   property p_enable_after;
      $rose(pulse_enable_out) |-> $past(pulse_channel_strobe_n) && !$past(pulse_channel_strobe_n, 2);
   endproperty
   a_enable_after: assert property (p_enable_after) else $error("enable not after strobe");
   property p_width;
      $fell(pulse_enable_out) |-> en_cnt_q == width_q;
   endproperty
   a_width: assert property (p_width) else $error("pulse width wrong");
   property p_one_select;
      $onehot0({!ram_select_n, !rom_select_n, counter_store_select, !pulse_channel_strobe_n});
   endproperty
   a_one_select: assert property (p_one_select) else $error("two selects");
   property p_addr_hold;
      sel_any && $past(sel_any) |-> $stable(local_addr) && $stable(read_write_n);
   endproperty
   a_addr_hold: assert property (p_addr_hold) else $error("address moved");
   property p_done_release;
      acc_done |-> !sel_any ##1 !acc_done;
   endproperty
   a_done_release: assert property (p_done_release) else $error("done with select");
   property p_fault_bound;
      sel_cnt_q <= 7'h40;
   endproperty
   a_fault_bound: assert property (p_fault_bound) else $error("cycle not aborted");
   property p_fault_release;
      acc_fault |-> !sel_any && sel_cnt_q >= 7'h20;
   endproperty
   a_fault_release: assert property (p_fault_release) else $error("abort too early");
   property p_rom_read;
      !rom_select_n |-> read_write_n && local_data_oe_n;
   endproperty
   a_rom_read: assert property (p_rom_read) else $error("rom driven");
   property p_pulse_fault;
      pulse_fault |-> (!pulse_enable_out) [*3];
   endproperty
   a_pulse_fault: assert property (p_pulse_fault) else $error("enable after fault");
   c_fault: cover property (acc_fault);
   c_pulse: cover property ($fell(pulse_enable_out));
   c_pfault: cover property (pulse_fault);
endmodule // local_bus_pulse_properties

bind local_bus_pulse local_bus_pulse_properties #(.UNIT_DIV_OFF(UNIT_DIV_OFF), .UNIT_DIV_ON(UNIT_DIV_ON)) i_props (
   .core_clk, .rstn, .pulse_cmd_valid, .pulse_cmd_ready, .pulse_code, .pulse_divide_sel, .acc_done,
   .acc_fault, .pulse_fault, .local_addr, .local_data_out, .local_data_oe_n, .read_write_n,
   .ram_select_n, .rom_select_n, .counter_store_select, .local_ack, .pulse_channel_strobe_n,
   .pulse_enable_out);

// >>> tb/mem_partner.sv
`timescale 1ns/10ps
// ==========
// Far-side memories, counter store and channel latch.
module mem_partner (
   // Clock and answer mode.
   input wire core_clk,
   input wire [1:0] ack_mode,
   // Local bus and strobe.
   input wire [10:0] local_addr,
   input wire [7:0] local_data_out,
   input wire local_data_oe_n,
   input wire read_write_n,
   input wire ram_select_n,
   input wire rom_select_n,
   input wire counter_store_select,
   input wire pulse_channel_strobe_n,
   output logic [7:0] local_data_in,
   output logic local_ack,
   output logic [7:0] latched_ch
);
   logic [7:0] ram [0:2047];
   logic [7:0] rom [0:1023];
   logic [7:0] cstore;
   logic [7:0] last_q = 8'h00;
   int wait_q = 0;
   wire sel = !ram_select_n || !rom_select_n || counter_store_select || !pulse_channel_strobe_n;
   always @(posedge core_clk) begin
      wait_q <= sel ? wait_q + 1 : 0;
      last_q <= local_data_in;
      if (!ram_select_n && !read_write_n) ram[local_addr] <= local_data_out;
      if (counter_store_select && !read_write_n) cstore <= local_data_out;
   end
   // The latch closes on the trailing edge of the strobe.
   always @(posedge pulse_channel_strobe_n) latched_ch <= local_data_out;
   // Mode 0 ties the acknowledge high, mode 1 answers late, mode 2 never.
   always @* begin
      local_ack = ack_mode == 2'h0 || (ack_mode == 2'h1 && sel && wait_q >= 10);
      if (!local_data_oe_n) local_data_in = local_data_out;
      else if (!ram_select_n) local_data_in = ram[local_addr];
      else if (!rom_select_n) local_data_in = rom[local_addr[9:0]];
      else if (counter_store_select) local_data_in = cstore;
      else local_data_in = ~last_q; // A released bus toggles so stale data cannot pass.
   end
endmodule // mem_partner

// >>> tb/testbench.sv
`timescale 1ns/10ps
// ==========
// Bench for the local bus and pulse unit.
module testbench;
   localparam int U_OFF = 40;
   localparam int U_ON = 8;
   logic core_clk, rstn, clk_en, acc_req, acc_write, acc_bank, pulse_cmd_valid, pulse_first;
   logic tail_length_select, pulse_divide_sel, acc_ready, acc_done, acc_fault, pulse_cmd_ready, pulse_fault;
   logic local_data_oe_n, read_write_n, ram_select_n, rom_select_n, counter_store_select, local_ack;
   logic pulse_channel_strobe_n, pulse_enable_out, bnk;
   logic [2:0] acc_kind, pulse_code;
   logic [9:0] acc_index, idx;
   logic [7:0] acc_wdata, acc_rdata, pulse_channel, local_data_in, local_data_out, latched_ch, dat;
   logic [10:0] local_addr;
   logic [1:0] ack_mode;
   int seed = 3517, n_fail = 0, cmp_count = 0, cyc = 0, last_fall = 0, n;
   local_bus_pulse #(.UNIT_DIV_OFF(U_OFF), .UNIT_DIV_ON(U_ON)) i_dut (
      .core_clk, .rstn, .clk_en, .acc_req, .acc_write, .acc_kind, .acc_bank, .acc_index, .acc_wdata,
      .acc_ready, .acc_done, .acc_fault, .acc_rdata, .pulse_cmd_valid, .pulse_first, .pulse_channel,
      .pulse_code, .pulse_cmd_ready, .pulse_fault, .tail_length_select, .pulse_divide_sel, .local_addr,
      .local_data_in, .local_data_out, .local_data_oe_n, .read_write_n, .ram_select_n, .rom_select_n,
      .counter_store_select, .local_ack, .pulse_channel_strobe_n, .pulse_enable_out);
   mem_partner i_mem (
      .core_clk, .ack_mode, .local_addr, .local_data_out, .local_data_oe_n, .read_write_n, .ram_select_n,
      .rom_select_n, .counter_store_select, .pulse_channel_strobe_n, .local_data_in, .local_ack, .latched_ch);
   initial begin
      core_clk = 0;
      forever #5 core_clk = ~core_clk;
   end
   always @(posedge core_clk) cyc <= cyc + 1;
   task chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         n_fail++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task conclude;
      $display("Comparisons %0d, mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   function automatic logic [10:0] ea(input logic [2:0] k, input logic b, input logic [9:0] i);
      case (k)
         3'h2: ea = (b ? 11'h100 : 11'h000) + i[7:0];
         3'h3: ea = 11'h600 + i[7:0];
         3'h4: ea = 11'h400;
         3'h5: ea = (b ? 11'h406 : 11'h402) + i[1:0];
         3'h6: ea = (b ? 11'h430 : 11'h410) + i[3:0];
         default: ea = {1'b0, i};
      endcase
   endfunction
   // Every task starts and ends just after an edge, so inputs never move on it.
   task xfer(input logic w, input logic [2:0] k, input logic b, input logic [9:0] i, input logic [7:0] d);
      n = 0;
      while (acc_ready !== 1'b1) @(posedge core_clk) #1;
      {acc_req, acc_write, acc_kind, acc_bank, acc_index, acc_wdata} = {1'b1, w, k, b, i, d};
      @(posedge core_clk) #1;
      acc_req = 0;
      while (acc_done !== 1'b1 && acc_fault !== 1'b1 && n < 100) begin
         @(posedge core_clk) #1;
         n++;
      end
   endtask
   task rd(input logic [2:0] k, input logic b, input logic [9:0] i, input logic [7:0] e);
      xfer(0, k, b, i, 8'h00);
      chk(acc_rdata, e);
   endtask
   task cmd(input logic [7:0] ch, input logic [2:0] c, input logic f);
      while (pulse_cmd_ready !== 1'b1) @(posedge core_clk) #1;
      {pulse_cmd_valid, pulse_channel, pulse_code, pulse_first} = {1'b1, ch, c, f};
      @(posedge core_clk) #1;
      pulse_cmd_valid = 0;
   endtask
   // The 24-cycle slack covers the strobe handshake, negligible at full units.
   task pulse(input logic [7:0] ch, input logic [2:0] c, input int u, input logic g);
      int t0;
      int w;
      cmd(ch, c, !g);
      t0 = cyc;
      while (pulse_enable_out !== 1'b1 && cyc - t0 < 4 * u + 99) @(posedge core_clk) #1;
      chk(latched_ch, ch);
      chk(cyc - t0 >= u / 2 && cyc - t0 <= u + u / 2 + 24, 1);
      if (g) chk(cyc - last_fall >= u / 2 && cyc - last_fall <= u + u / 2 + 24, 1);
      w = 0;
      while (pulse_enable_out === 1'b1 && w < 9000) begin
         @(posedge core_clk) #1;
         w++;
      end
      last_fall = cyc;
      chk(w, (u << c) + 1);
   endtask
   initial begin
      {rstn, acc_req, acc_write, acc_kind, acc_bank, acc_index, acc_wdata, ack_mode} = '0;
      {pulse_cmd_valid, pulse_first, pulse_channel, pulse_code, pulse_divide_sel} = '0;
      clk_en = 1;
      tail_length_select = 1;
      i_mem.rom[0] = 8'hff;
      i_mem.rom[5] = 8'hff;
      i_mem.rom[3] = 8'h63;
      i_mem.rom[10'h368] = 8'h05;
      repeat (20) @(posedge core_clk);
      #1 rstn = 1;
      repeat (3) @(posedge core_clk) #1;
      chk({local_addr, local_data_oe_n, read_write_n, ram_select_n, rom_select_n, counter_store_select,
           pulse_channel_strobe_n, pulse_enable_out}, {11'h000, 7'h7a});
      for (int t = 0; t < 2; t++) begin
         tail_length_select = t[0];
         repeat (10) @(posedge core_clk) #1;
         for (int k = 0; k < 7; k++) begin
            if (k != 1) begin
               bnk = $random(seed);
               idx = $random(seed);
               dat = $random(seed);
               idx = (k == 6) ? idx % 14 : idx;
               xfer(1, k[2:0], bnk, idx, dat);
               chk(n, 5);
               chk((k == 4 && !t) ? i_mem.cstore : i_mem.ram[ea(k[2:0], bnk, idx)], dat);
               rd(k[2:0], bnk, idx, dat);
            end
         end
      end
      rd(3'h7, 0, 10'h000, 8'hcf);
      rd(3'h7, 0, 10'h005, 8'h3f);
      rd(3'h7, 0, 10'h003, 8'h63);
      rd(3'h1, 0, 10'h368, 8'h05);
      for (int v = 0; v < 2; v++) begin
         pulse_divide_sel = v[0];
         repeat (10) @(posedge core_clk) #1;
         for (int c = 0; c < 8; c++) pulse($random(seed), c[2:0], v ? U_ON : U_OFF, c != 0);
      end
      ack_mode = 1;
      xfer(1, 3'h0, 0, 10'h055, 8'h5a);
      chk(n > 10, 1);
      rd(3'h0, 0, 10'h055, 8'h5a);
      pulse(8'ha5, 3'h1, U_ON, 0);
      ack_mode = 2;
      xfer(0, 3'h2, 1, 10'h010, 8'h00);
      chk(acc_fault && n >= 33 && n <= 65, 1);
      cmd(8'h3c, 3'h0, 1);
      n = 0;
      while (pulse_fault !== 1'b1 && n < 200) begin
         @(posedge core_clk) #1;
         n++;
      end
      chk(pulse_fault, 1);
      repeat (3) @(posedge core_clk) #1;
      chk(pulse_enable_out, 0);
      ack_mode = 0;
      clk_en = 0;
      {acc_req, acc_write, acc_kind, acc_index} = {1'b1, 1'b0, 3'h0, 10'h055};
      repeat (8) @(posedge core_clk) #1;
      chk(ram_select_n, 1);
      clk_en = 1;
      @(posedge core_clk) #1;
      acc_req = 0;
      chk(ram_select_n, 0);
      conclude;
   end
   initial begin
      #(60000 * 10);
      n_fail++;
      conclude;
   end
endmodule // testbench
